// ===== verilog/image_format_defs.svh
// Offsets, field positions, reset values and timing for the image format inquiry registers
// Overview of operation
// - Upper half reports column step for AOI
// - Lower half reports row step for AOI
// - Frame period word is IEEE single float
// - Period recomputed when its settings change
// - Depth field follows selected colour coding
// - Mosaic phase follows AOI origin parity
// - Top validity bit reads one when valid
// - Geometry error flag blocks capture start
// - Packet size error flag blocks capture
// - Packet size write refreshes packet flag
// - Unused and reserved positions carry nothing
// - Bit zero is the word's MSB
`ifndef IMAGE_FORMAT_DEFS_SVH
`define IMAGE_FORMAT_DEFS_SVH

// ==========================================================
// Register offsets
`define OFS_POSITION   12'h008
`define OFS_SIZE       12'h00C
`define OFS_CODING     12'h010
`define OFS_SPEED      12'h014
`define OFS_PKT_SIZE   12'h044
`define OFS_STEP       12'h04C
`define OFS_PERIOD     12'h050
`define OFS_DEPTH      12'h054
`define OFS_MOSAIC     12'h058
`define OFS_VALIDITY   12'h07C
`define OFS_IRQ_STAT   12'h080
`define OFS_IRQ_MASK   12'h084
`define OFS_CAPTURE    12'h088

// ==========================================================
// Field positions, counted as SystemVerilog bit indices (MSB is index 31)
`define VAL_PRESENT_BIT 31
`define VAL_GEO_BIT     23
`define VAL_PKT_BIT     22
`define CAP_START_BIT   31
`define IRQ_GEO_BIT     0
`define IRQ_PKT_BIT     1
`define IRQ_REFUSE_BIT  2
`define IRQ_WIDTH       3

// ==========================================================
// Reset values and timing
`define RST_WORD        32'h0000_0000
`define RST_PKT_SIZE    16'h0000
`define SPEED_MAX       3'h3
`define PERIOD_EXP_BIAS 8'h67
`define DEPTH_8         8'h08
`define DEPTH_12        8'h0C

`endif

// ===== verilog/image_format_pkg.sv
// Types shared by the image format inquiry register block
package image_format_pkg;

  typedef enum logic [7:0] {
    CC_MONO8  = 8'h00,
    CC_YUV8   = 8'h01,
    CC_RGB8   = 8'h02,
    CC_MONO12 = 8'h03,
    CC_RAW8   = 8'h04,
    CC_RAW12  = 8'h05
  } color_code_t;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } apb_req_t;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] top;
    logic [15:0] width;
    logic [15:0] height;
  } geometry_t;

endpackage

// ===== verilog/image_format_inquiry_regs.sv
// APB register block reporting image format inquiry words and settings validity
`timescale 1ns/1ps
`include "image_format_defs.svh"

module image_format_inquiry_regs
  import image_format_pkg::*;
#(
  parameter logic [15:0] SENSOR_W   = 16'h0280,
  parameter logic [15:0] SENSOR_H   = 16'h01E0,
  parameter logic [15:0] H_UNIT     = 16'h0001,
  parameter logic [15:0] V_UNIT     = 16'h0001,
  parameter logic [15:0] PKT_UNIT   = 16'h0004,
  parameter logic [15:0] PKT_MAX    = 16'h0400,
  parameter logic [15:0] V_BLANK    = 16'h0010,
  parameter logic [15:0] LINE_UNITS = 16'h0200,
  parameter logic [1:0]  MOSAIC_BASE = 2'h0
) (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             IRQ_O,
  output logic             CAPTURE_START_O
);

  // ==========================================================
  // Bus request and decode
  apb_req_t req;
  logic     setup;
  logic     wr_acc;

  assign req    = '{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, PSTRB_I};
  assign setup  = req.sel & ~req.enable;
  assign wr_acc = req.sel & req.enable & req.write & PREADY_O;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Settings and bus state
  geometry_t            geo_reg, geo_next;
  logic [7:0]           coding_reg, coding_next;
  logic [2:0]           speed_reg, speed_next;
  logic [15:0]          pkt_reg, pkt_next;
  logic [`IRQ_WIDTH-1:0] mask_reg, mask_next;
  logic                 geo_eval_reg, geo_eval_next;
  logic                 pkt_eval_reg, pkt_eval_next;
  logic [31:0]          prdata_next;
  logic                 pready_next;
  logic                 pslverr_next;
  logic [31:0]          rd_word;
  logic [31:0]          pkt_merged;
  logic                 rd_hit;
  logic [31:0]          step_word, period_word, depth_word, mosaic_word, valid_word;
  logic [`IRQ_WIDTH-1:0] stat_reg;
  logic                 geo_err_reg, pkt_err_reg, valid_reg;
  logic [31:0]          period_reg;

  assign pkt_merged = merge({pkt_reg, 16'h0000}, req.wdata, req.strb);

  // Geometry, coding and speed are one settings group for geometry evaluation
  always_comb begin
    geo_next      = geo_reg;
    coding_next   = coding_reg;
    speed_next    = speed_reg;
    pkt_next      = pkt_reg;
    mask_next     = mask_reg;
    geo_eval_next = 1'b0;
    pkt_eval_next = 1'b0;
    if (wr_acc) begin
      unique case (req.addr)
        `OFS_POSITION: begin
          {geo_next.left, geo_next.top} = merge({geo_reg.left, geo_reg.top}, req.wdata, req.strb);
          geo_eval_next = 1'b1;
        end
        `OFS_SIZE: begin
          {geo_next.width, geo_next.height} =
            merge({geo_reg.width, geo_reg.height}, req.wdata, req.strb);
          geo_eval_next = 1'b1;
        end
        `OFS_CODING: begin
          if (req.strb[3]) begin
            coding_next = req.wdata[31:24];
          end
          geo_eval_next = 1'b1;
        end
        `OFS_SPEED: begin
          if (req.strb[3]) begin
            speed_next = req.wdata[31:29];
          end
          geo_eval_next = 1'b1;
          pkt_eval_next = 1'b1;
        end
        `OFS_PKT_SIZE: begin
          // Packet size sits in bit positions 0..15, i.e. the upper half
          pkt_next = pkt_merged[31:16];
          pkt_eval_next = 1'b1;
        end
        `OFS_IRQ_MASK: mask_next = req.wdata[`IRQ_WIDTH-1:0];
        default: ; // Read-only and unmapped words keep no state
      endcase
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    rd_hit = 1'b1;
    unique case (req.addr)
      `OFS_POSITION: rd_word = {geo_reg.left, geo_reg.top};
      `OFS_SIZE:     rd_word = {geo_reg.width, geo_reg.height};
      `OFS_CODING:   rd_word = {coding_reg, 24'h00_0000};
      `OFS_SPEED:    rd_word = {speed_reg, 29'h0000_0000};
      `OFS_PKT_SIZE: rd_word = {pkt_reg, 16'h0000};
      `OFS_STEP:     rd_word = step_word;
      `OFS_PERIOD:   rd_word = period_word;
      `OFS_DEPTH:    rd_word = depth_word;
      `OFS_MOSAIC:   rd_word = mosaic_word;
      `OFS_VALIDITY: rd_word = valid_word;
      `OFS_IRQ_STAT: rd_word = {29'h0000_0000, stat_reg};
      `OFS_IRQ_MASK: rd_word = {29'h0000_0000, mask_reg};
      `OFS_CAPTURE:  rd_word = `RST_WORD;
      default: begin
        rd_word = `RST_WORD;
        rd_hit  = 1'b0;
      end
    endcase
    // Zero wait: answer is registered during setup, ready in the access cycle
    pready_next  = setup;
    prdata_next  = (setup & ~req.write) ? rd_word : `RST_WORD;
    pslverr_next = setup & ~rd_hit;
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      geo_reg      <= '0;
      coding_reg   <= CC_MONO8;
      speed_reg    <= 3'h0;
      pkt_reg      <= `RST_PKT_SIZE;
      mask_reg     <= '0;
      geo_eval_reg <= 1'b1;
      pkt_eval_reg <= 1'b1;
      PRDATA_O     <= `RST_WORD;
      PREADY_O     <= 1'b0;
      PSLVERR_O    <= 1'b0;
    end else begin
      geo_reg      <= geo_next;
      coding_reg   <= coding_next;
      speed_reg    <= speed_next;
      pkt_reg      <= pkt_next;
      mask_reg     <= mask_next;
      geo_eval_reg <= geo_eval_next;
      pkt_eval_reg <= pkt_eval_next;
      PRDATA_O     <= prdata_next;
      PREADY_O     <= pready_next;
      PSLVERR_O    <= pslverr_next;
    end
  end

  // ==========================================================
  // Evaluation of settings
  logic        geo_bad, pkt_bad, coding_ok;
  logic [16:0] right_edge, bottom_edge, pkt_max;
  logic [31:0] period_count, period_float;
  logic [7:0]  depth;
  logic        cap_req, refuse;

  assign right_edge  = {1'b0, geo_reg.left} + {1'b0, geo_reg.width};
  assign bottom_edge = {1'b0, geo_reg.top} + {1'b0, geo_reg.height};
  assign pkt_max     = 17'({1'b0, PKT_MAX} << speed_reg);

  always_comb begin
    coding_ok = 1'b1;
    unique case (coding_reg)
      CC_MONO8, CC_RAW8:   depth = `DEPTH_8;
      CC_YUV8, CC_RGB8:    depth = `DEPTH_8;  // Per component
      CC_MONO12, CC_RAW12: depth = `DEPTH_12;
      default: begin
        depth     = 8'h00;
        coding_ok = 1'b0;
      end
    endcase
  end

  assign geo_bad = (geo_reg.width == 16'h0000) | (geo_reg.height == 16'h0000) |
                   (right_edge > {1'b0, SENSOR_W}) | (bottom_edge > {1'b0, SENSOR_H}) |
                   ((geo_reg.left % H_UNIT) != 16'h0000) |
                   ((geo_reg.top % V_UNIT) != 16'h0000) |
                   ~coding_ok | (speed_reg > `SPEED_MAX);
  assign pkt_bad = (pkt_reg == 16'h0000) | ((pkt_reg % PKT_UNIT) != 16'h0000) |
                   ({1'b0, pkt_reg} > pkt_max) | (speed_reg > `SPEED_MAX);

  // Period counted in units of 2^-24 s, then normalised to a float (truncating)
  assign period_count = 32'({16'h0000, geo_reg.height} + {16'h0000, V_BLANK}) *
                        32'({16'h0000, LINE_UNITS});
  always_comb begin
    int msb;
    msb = 0;
    for (int i = 0; i < 32; i++) begin
      if (period_count[i]) begin
        msb = i;
      end
    end
    if (period_count == 32'h0000_0000) begin
      period_float = 32'h0000_0000;
    end else if (msb <= 23) begin
      period_float = {1'b0, 8'(msb) + `PERIOD_EXP_BIAS,
                      23'(period_count << (23 - msb))};
    end else begin
      period_float = {1'b0, 8'(msb) + `PERIOD_EXP_BIAS,
                      23'(period_count >> (msb - 23))};
    end
  end

  assign step_word   = {H_UNIT, V_UNIT};
  assign period_word = period_reg;
  assign depth_word  = {depth, 24'h00_0000};
  assign mosaic_word = {6'h00, MOSAIC_BASE ^ {geo_reg.left[0], geo_reg.top[0]},
                        24'h00_0000};
  // Presence, then the unused bits 1..7 and reserved bits as zero
  assign valid_word  = {valid_reg, 7'h00, geo_err_reg, pkt_err_reg,
                        22'h00_0000};

  assign cap_req = wr_acc & (req.addr == `OFS_CAPTURE) & req.strb[3] &
                   req.wdata[`CAP_START_BIT];
  // A pending evaluation also refuses, so a start never races a settings write
  assign refuse  = geo_err_reg | pkt_err_reg | ~valid_reg | geo_eval_reg | pkt_eval_reg;

  // ==========================================================
  // Flags, interrupts and capture start
  logic                  geo_err_next, pkt_err_next, valid_next, start_next, irq_next;
  logic [31:0]           period_next;
  logic [`IRQ_WIDTH-1:0] stat_next, events, clr;

  always_comb begin
    geo_err_next = geo_eval_reg ? geo_bad : geo_err_reg;
    pkt_err_next = pkt_eval_reg ? pkt_bad : pkt_err_reg;
    valid_next   = valid_reg | geo_eval_reg;
    period_next  = geo_eval_reg ? period_float : period_reg;
    start_next   = cap_req & ~refuse;
    events       = '0;
    events[`IRQ_GEO_BIT]    = geo_err_next & ~geo_err_reg;
    events[`IRQ_PKT_BIT]    = pkt_err_next & ~pkt_err_reg;
    events[`IRQ_REFUSE_BIT] = cap_req & refuse;
    clr = (wr_acc & (req.addr == `OFS_IRQ_STAT)) ? req.wdata[`IRQ_WIDTH-1:0] : '0;
    // Set wins over a write-one clear in the same cycle
    stat_next = (stat_reg & ~clr) | events;
    irq_next  = |(stat_next & mask_next);
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      geo_err_reg     <= 1'b0;
      pkt_err_reg     <= 1'b0;
      valid_reg       <= 1'b0;
      period_reg      <= `RST_WORD;
      stat_reg        <= '0;
      IRQ_O           <= 1'b0;
      CAPTURE_START_O <= 1'b0;
    end else begin
      geo_err_reg     <= geo_err_next;
      pkt_err_reg     <= pkt_err_next;
      valid_reg       <= valid_next;
      period_reg      <= period_next;
      stat_reg        <= stat_next;
      IRQ_O           <= irq_next;
      CAPTURE_START_O <= start_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  // Reset is sampled as well: the release edge still shows reset-time flags
  property p_geo_refresh;
    (RESET_N_I && geo_eval_reg) |=> (geo_err_reg == $past(geo_bad));
  endproperty
  a_geo_refresh: assert property (p_geo_refresh) else $error("geometry flag stale");

  property p_pkt_write;
    (wr_acc && req.addr == `OFS_PKT_SIZE) |=> pkt_eval_reg ##1 (pkt_err_reg == $past(pkt_bad));
  endproperty
  a_pkt_write: assert property (p_pkt_write) else $error("packet flag not refreshed");

  property p_period;
    (RESET_N_I && geo_eval_reg) |=> (period_reg == $past(period_float));
  endproperty
  a_period: assert property (p_period) else $error("frame period not recomputed");

  property p_refuse;
    (cap_req && (geo_err_reg || pkt_err_reg)) |=> !CAPTURE_START_O && stat_reg[`IRQ_REFUSE_BIT];
  endproperty
  a_refuse: assert property (p_refuse) else $error("capture started with error");

  property p_valid_read;
    (setup && !req.write && req.addr == `OFS_VALIDITY) |=>
      PREADY_O && PRDATA_O[`VAL_PRESENT_BIT] == valid_reg && PRDATA_O[30:24] == 7'h00;
  endproperty
  a_valid_read: assert property (p_valid_read) else $error("validity word wrong");

  property p_depth_read;
    (setup && !req.write && req.addr == `OFS_DEPTH) |=>
      PRDATA_O[23:0] == 24'h00_0000 && PRDATA_O[31:24] != 8'h00 == coding_ok;
  endproperty
  a_depth_read: assert property (p_depth_read) else $error("depth word wrong");

  property p_ro_write;
    (wr_acc && req.addr == `OFS_STEP) |=> $stable(geo_reg) && $stable(pkt_reg);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_set_wins;
    (RESET_N_I && events != '0) |=> ((stat_reg & $past(events)) == $past(events));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_start_ok;
    CAPTURE_START_O |-> $past(cap_req) && !geo_err_reg && !pkt_err_reg && valid_reg;
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("start without request");

endmodule

// ===== verif/image_format_inquiry_regs_tb_top.sv
// Self-checking testbench for the image format inquiry register block
`timescale 1ns/1ps
`include "image_format_defs.svh"

module image_format_inquiry_regs_tb_top;

  // ==========================================================
  // Signals
  typedef struct {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] re;
  } row_t;

  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        cap;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          checks_done;
  int          cycles;
  int          cap_count;
  int          c0;

  // Write, then read back what the rules predict for the new settings
  row_t rows [30] = '{
    '{`OFS_SIZE, 32'h0280_01E0, `OFS_PERIOD, 32'h3C78_0000},
    '{`OFS_PKT_SIZE, 32'h0400_0000, `OFS_VALIDITY, 32'h8000_0000},
    '{`OFS_SIZE, 32'h0200_0010, `OFS_PERIOD, 32'h3A80_0000},
    '{`OFS_PKT_SIZE, 32'h0402_0000, `OFS_VALIDITY, 32'h8040_0000},
    '{`OFS_PKT_SIZE, 32'h0404_0000, `OFS_VALIDITY, 32'h8040_0000},
    '{`OFS_PKT_SIZE, 32'h0004_0000, `OFS_VALIDITY, 32'h8000_0000},
    '{`OFS_CODING, 32'h0100_0000, `OFS_DEPTH, 32'h0800_0000},
    '{`OFS_CODING, 32'h0200_0000, `OFS_DEPTH, 32'h0800_0000},
    '{`OFS_CODING, 32'h0300_0000, `OFS_DEPTH, 32'h0C00_0000},
    '{`OFS_CODING, 32'h0400_0000, `OFS_DEPTH, 32'h0800_0000},
    '{`OFS_CODING, 32'h0500_0000, `OFS_DEPTH, 32'h0C00_0000},
    '{`OFS_CODING, 32'h0600_0000, `OFS_VALIDITY, 32'h8080_0000},
    '{`OFS_CODING, 32'h0000_0000, `OFS_DEPTH, 32'h0800_0000},
    '{`OFS_POSITION, 32'h0001_0000, `OFS_MOSAIC, 32'h0200_0000},
    '{`OFS_POSITION, 32'h0000_0001, `OFS_MOSAIC, 32'h0100_0000},
    '{`OFS_POSITION, 32'h0001_0001, `OFS_MOSAIC, 32'h0300_0000},
    '{`OFS_POSITION, 32'h0181_0000, `OFS_VALIDITY, 32'h8080_0000},
    '{`OFS_POSITION, 32'h0000_01D1, `OFS_VALIDITY, 32'h8080_0000},
    '{`OFS_POSITION, 32'h0000_0000, `OFS_MOSAIC, 32'h0000_0000},
    '{`OFS_SPEED, 32'h8000_0000, `OFS_VALIDITY, 32'h80C0_0000},
    '{`OFS_SPEED, 32'h2000_0000, `OFS_VALIDITY, 32'h8000_0000},
    '{`OFS_PKT_SIZE, 32'h0800_0000, `OFS_VALIDITY, 32'h8000_0000},
    '{`OFS_SPEED, 32'h0000_0000, `OFS_VALIDITY, 32'h8040_0000},
    '{`OFS_PKT_SIZE, 32'h0400_FFFF, `OFS_PKT_SIZE, 32'h0400_0000},
    '{`OFS_STEP, 32'hFFFF_FFFF, `OFS_STEP, 32'h0001_0001},
    '{`OFS_VALIDITY, 32'hFFFF_FFFF, `OFS_VALIDITY, 32'h8000_0000},
    '{`OFS_DEPTH, 32'hFFFF_FFFF, `OFS_DEPTH, 32'h0800_0000},
    '{`OFS_SIZE, 32'h0000_0010, `OFS_VALIDITY, 32'h8080_0000},
    '{`OFS_SIZE, 32'h0200_0010, `OFS_VALIDITY, 32'h8000_0000},
    '{`OFS_PERIOD, 32'hFFFF_FFFF, `OFS_PERIOD, 32'h3A80_0000}
  };

  image_format_inquiry_regs image_format_inquiry_regs_i (
    .CLK_I           (clk),
    .RESET_N_I       (reset_n),
    .PSEL_I          (psel),
    .PENABLE_I       (penable),
    .PWRITE_I        (pwrite),
    .PADDR_I         (paddr),
    .PWDATA_I        (pwdata),
    .PSTRB_I         (pstrb),
    .PRDATA_O        (prdata),
    .PREADY_O        (pready),
    .PSLVERR_O       (pslverr),
    .IRQ_O           (irq),
    .CAPTURE_START_O (cap)
  );

  // ==========================================================
  // Clock, timeout and start pulse counter
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cap === 1'b1) begin
      cap_count++;
    end
    if (cycles == 6000) begin
      bad_count++;
      test_done();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is sampled high; only the timeout ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reset_dut(input int k);
    reset_n <= 1'b0;
    repeat (k) @(posedge clk);
    #1;
    chk32({prdata[27:0], pready, pslverr, irq, cap}, 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
    reset_dut(15);
    apb(0, `OFS_VALIDITY, 0);
    chk32(rd, 32'h80C0_0000);
    apb(0, `OFS_IRQ_STAT, 0);
    chk32(rd, 32'h0000_0003);
    apb(1, `OFS_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk32({31'h0, irq}, 32'h0000_0001);
    apb(1, `OFS_IRQ_STAT, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk32({31'h0, irq}, 32'h0000_0000);
    // Start request with bad settings must be refused
    c0 = cap_count;
    apb(1, `OFS_CAPTURE, 32'h8000_0000);
    repeat (3) @(posedge clk);
    chk32(cap_count, c0);
    apb(0, `OFS_IRQ_STAT, 0);
    chk32(rd, 32'h0000_0006);
    apb(1, `OFS_IRQ_MASK, 32'h0000_0000);
    for (int i = 0; i < 30; i++) begin
      apb(1, rows[i].wa, rows[i].wd);
      apb(0, rows[i].ra, 0);
      chk32({rd[31:1], er}, {rows[i].re[31:1], 1'b0});
      chk32(rd, rows[i].re);
    end
    // ==========================================================
    // Awkward cases: start accepted, refused after packet error, unmapped place
    c0 = cap_count;
    apb(1, `OFS_CAPTURE, 32'h8000_0000);
    repeat (3) @(posedge clk);
    chk32(cap_count, c0 + 1);
    apb(1, `OFS_IRQ_STAT, 32'h0000_0007);
    apb(1, `OFS_IRQ_MASK, 32'h0000_0004);
    apb(1, `OFS_PKT_SIZE, 32'h0402_0000);
    apb(1, `OFS_CAPTURE, 32'h8000_0000);
    repeat (3) @(posedge clk);
    chk32(cap_count, c0 + 1);
    chk32({31'h0, irq}, 32'h0000_0001);
    apb(0, `OFS_IRQ_STAT, 0);
    chk32(rd, 32'h0000_0006);
    apb(0, 12'h0FC, 0);
    chk32({rd[31:1], er}, 32'h0000_0001);
    apb(1, 12'h0FC, 32'hFFFF_FFFF);
    chk32({31'h0, er}, 32'h0000_0001);
    // Second reset in mid-run brings back the defaults
    reset_dut(3);
    apb(0, `OFS_VALIDITY, 0);
    chk32(rd, 32'h80C0_0000);
    apb(0, `OFS_PKT_SIZE, 0);
    chk32(rd, 32'h0000_0000);
    apb(0, `OFS_STEP, 0);
    chk32(rd, 32'h0001_0001);
    // Byte strobes: only the low byte of the origin lands, coding needs its top byte
    apb(1, `OFS_POSITION, 32'h1235_0004, 4'h1);
    apb(0, `OFS_POSITION, 0);
    chk32(rd, 32'h0000_0004);
    apb(0, `OFS_MOSAIC, 0);
    chk32(rd, 32'h0000_0000);
    apb(1, `OFS_CODING, 32'h0300_0000, 4'h7);
    apb(0, `OFS_DEPTH, 0);
    chk32(rd, 32'h0800_0000);
    test_done();
  end

endmodule
